// >>> include/pmc_pkg.sv
// Package for the per-port PHY mode and special-modes register pair.
// Assumes one 250 MHz system clock and register access by 5-bit index.
package pmc_pkg;

  // ----------------------------------------------------------------------
  // Register indices and field layout
  // ----------------------------------------------------------------------
  localparam logic [4:0] IDX_ENERGY_MODE_CTL_STAT = 5'h11;
  localparam logic [4:0] IDX_OPERATING_MODE_ADDR  = 5'h12;
  localparam int         EDPD_BIT                 = 13;
  localparam int         ENERGY_BIT               = 1;
  localparam int         RSVD_RW_BIT              = 0;
  localparam int         MODE_LSB                 = 5;
  localparam int         MODE_MSB                 = 7;
  localparam int         ADDR_LSB                 = 0;
  localparam int         ADDR_MSB                 = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic       EDPD_RST                 = 1'b0;
  localparam logic       RSVD_RW_RST              = 1'b0;
  localparam logic       ENERGY_RST               = 1'b1;
  localparam logic [2:0] MODE_AUTONEG_RST         = 3'h7;
  localparam logic       MODE_FORCED_TOP_RST      = 1'b0;
  localparam logic [4:0] ADDR_SEL0_DEF            = 5'h01;
  localparam logic [4:0] ADDR_SEL1_DEF            = 5'h02;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int         CLK_KHZ                  = 250000;
  localparam int         ENERGY_TIMEOUT_MS        = 256;
  localparam int         ENERGY_TIMEOUT_CYC       = ENERGY_TIMEOUT_MS * CLK_KHZ;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {INIT_SYNC0, INIT_SYNC1, INIT_LATCH, INIT_RUN} pmc_init_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  idx;
    logic [15:0] wdata;
  } pmc_reg_req_t;

  typedef struct packed {
    logic autoneg;
    logic speed;
    logic duplex;
    logic addrSel;
  } pmc_straps_t;

  // Basic-control bits are ordered [13,12,10,8]; advert bits [8,7,6,5].
  typedef struct packed {
    logic [3:0] basicMask;
    logic [3:0] basicVal;
    logic [3:0] advMask;
    logic [3:0] advVal;
    logic       crsTxRx;
    logic       repeater;
    logic       powerDown;
  } pmc_mode_drive_t;

  typedef struct packed {
    logic        on;
    logic [31:0] cnt;
  } pmc_energy_state_t;

  typedef struct packed {
    pmc_straps_t     strapSync1;
    pmc_straps_t     strapSync2;
    logic            energySync1;
    logic            energySync2;
    pmc_init_t       init;
    pmc_straps_t     straps;
    logic            edpd;
    logic            rsvdRw;
    logic [2:0]      mode;
    logic [4:0]      addr;
    pmc_mode_drive_t drive;
    logic            modeApply;
    logic            loaderReq;
    logic [15:0]     rdData;
    logic            rdValid;
  } pmc_top_state_t;

  // Full-duplex modes keep carrier sense to receive only.
  function automatic pmc_mode_drive_t pmcModeDecode(input logic [2:0] mode);
    pmc_mode_drive_t d;
    d = '0;
    case (mode)
      3'h0: begin
        d.basicMask = 4'hf;
        d.basicVal  = 4'h0;
        d.crsTxRx   = 1'b1;
      end
      3'h1: begin
        d.basicMask = 4'hf;
        d.basicVal  = 4'h1;
      end
      3'h2: begin
        d.basicMask = 4'hf;
        d.basicVal  = 4'h8;
        d.crsTxRx   = 1'b1;
      end
      3'h3: begin
        d.basicMask = 4'hf;
        d.basicVal  = 4'h9;
      end
      3'h4: begin
        d.basicMask = 4'hf;
        d.basicVal  = 4'hc;
        d.advMask   = 4'hf;
        d.advVal    = 4'h4;
        d.crsTxRx   = 1'b1;
      end
      3'h5: begin
        d.basicMask = 4'hf;
        d.basicVal  = 4'hc;
        d.advMask   = 4'hf;
        d.advVal    = 4'h4;
        d.repeater  = 1'b1;
      end
      3'h6: begin
        d.powerDown = 1'b1;
      end
      3'h7: begin
        d.basicMask = 4'h6;
        d.basicVal  = 4'h4;
        d.advMask   = 4'hf;
        d.advVal    = 4'hf;
        d.crsTxRx   = 1'b1;
      end
      default: d = '0;
    endcase
    return d;
  endfunction

endpackage

// >>> hw/pmc_energy_monitor.sv
// Line energy status: holds high while energy is seen, drops after a quiet timeout.
// Assumes energySeen is already synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module pmc_energy_monitor #(
  parameter int TIMEOUT_CYC = pmc_pkg::ENERGY_TIMEOUT_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rstSync_n,
  input  wire logic clkEn,
  input  wire logic forceOn,
  input  wire logic energySeen,
  output logic      lineEnergyPresent
);

  pmc_pkg::pmc_energy_state_t q;
  pmc_pkg::pmc_energy_state_t d;
  localparam logic [31:0] LAST_CNT = 32'(TIMEOUT_CYC - 1);

  always_comb begin
    d = q;
    if (forceOn) begin
      d.on  = 1'b1;
      d.cnt = '0;
    end else if (energySeen) begin
      d.on  = 1'b1;
      d.cnt = '0;
    end else if (q.on) begin
      if (q.cnt == LAST_CNT) begin
        d.on  = 1'b0;
        d.cnt = '0;
      end else begin
        d.cnt = q.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      q.on  <= pmc_pkg::ENERGY_RST;
      q.cnt <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign lineEnergyPresent = q.on;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_energy_sets_on: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    clkEn && energySeen |=> lineEnergyPresent)
    else $error("Energy seen did not set the status.");

  a_energy_times_out: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    clkEn && q.on && !energySeen && !forceOn && q.cnt == LAST_CNT |=> !lineEnergyPresent)
    else $error("Energy status did not clear at the timeout.");

  a_energy_quiet_holds: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    clkEn && q.on && !energySeen && !forceOn && q.cnt < LAST_CNT |=> lineEnergyPresent && q.cnt == $past(q.cnt) + 32'h1)
    else $error("Energy status dropped or counter stalled before the timeout.");

endmodule // pmc_energy_monitor

`default_nettype wire

// >>> hw/pmc_phy_mode_regs.sv
// Per-port PHY energy/mode control register and operating-mode/address register.
// Assumes strap and line-energy pins are asynchronous; everything else is on clk_sys.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bit 13 enables energy-detect power-down.
// - Energy status tracks line, clears after timeout.
// - Hardware reset sets energy; software reset keeps it.
// - Loader rewrites modes after reset and reload.
// - Autoneg strap high gives mode 111.
// - Otherwise mode is 0, speed, duplex straps.
// - Straps latched at chip reset release.
// - Address field sets management address and scrambler.
// - Address default comes from address-select strap.
// - Protected bits reset only by chip reset or port PHY reset.
// - Mode drives basic-control and advertisement bits.
// - Mode 000: 10M half, control 0000.
// - Mode 001: 10M full, control 0001.
// - Mode 010: 100M half, carrier on both.
// - Mode 011: 100M full, control 1001.
// - Mode 100: autoneg, control 1100, advert 0100.
// - Mode 101: repeater, as 100, carrier receive.
// - Mode 110: power-down, bits left unchanged.
// - Mode 111: advert 1111, control X10X.
module pmc_phy_mode_regs #(
  parameter int         ENERGY_TIMEOUT_CYC = pmc_pkg::ENERGY_TIMEOUT_CYC,
  parameter logic [4:0] ADDR_SEL0          = pmc_pkg::ADDR_SEL0_DEF,
  parameter logic [4:0] ADDR_SEL1          = pmc_pkg::ADDR_SEL1_DEF
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   clkEn,
  input  wire pmc_pkg::pmc_reg_req_t  regReq,
  output logic [15:0]                 regRdData,
  output logic                        regRdValid,
  input  wire logic                   softResetPulse,
  input  wire logic                   phyResetPulse,
  input  wire logic                   reloadCmd,
  input  wire logic                   loaderWrEn,
  input  wire logic [15:0]            loaderWrData,
  output logic                        loaderReq,
  input  wire pmc_pkg::pmc_straps_t   strapPins,
  input  wire logic                   lineEnergyPin,
  output logic                        energyDetectPowerdownEn,
  output logic                        lineEnergyPresent,
  output logic [4:0]                  phyMgmtAddress,
  output logic [4:0]                  scramblerSeed,
  output logic [2:0]                  phyMode,
  output pmc_pkg::pmc_mode_drive_t    modeDrive,
  output logic                        modeApply
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rstMeta_q;
  logic rstSync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Strap decoding
  // ----------------------------------------------------------------------
  function automatic logic [2:0] strapMode(input pmc_pkg::pmc_straps_t s);
    logic [2:0] m;
    m = {pmc_pkg::MODE_FORCED_TOP_RST, s.speed, s.duplex};
    if (s.autoneg) begin
      m = pmc_pkg::MODE_AUTONEG_RST;
    end
    return m;
  endfunction

  function automatic logic [4:0] strapAddr(input pmc_pkg::pmc_straps_t s);
    return s.addrSel ? ADDR_SEL1 : ADDR_SEL0;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  pmc_pkg::pmc_top_state_t q;
  pmc_pkg::pmc_top_state_t d;
  logic                    line_energy_present;
  logic                    wrCtlStat;
  logic                    wrModeAddr;

  assign wrCtlStat  = regReq.wr && regReq.idx == pmc_pkg::IDX_ENERGY_MODE_CTL_STAT;
  assign wrModeAddr = regReq.wr && regReq.idx == pmc_pkg::IDX_OPERATING_MODE_ADDR;

  always_comb begin
    d           = q;
    d.modeApply = 1'b0;
    d.loaderReq = 1'b0;
    d.rdValid   = 1'b0;
    d.strapSync1  = strapPins;
    d.strapSync2  = q.strapSync1;
    d.energySync1 = lineEnergyPin;
    d.energySync2 = q.energySync1;
    case (q.init)
      pmc_pkg::INIT_SYNC0: begin
        d.init = pmc_pkg::INIT_SYNC1;
      end
      pmc_pkg::INIT_SYNC1: begin
        d.init = pmc_pkg::INIT_LATCH;
      end
      pmc_pkg::INIT_LATCH: begin
        d.straps    = q.strapSync2;
        d.mode      = strapMode(q.strapSync2);
        d.addr      = strapAddr(q.strapSync2);
        d.modeApply = 1'b1;
        d.loaderReq = 1'b1;
        d.init      = pmc_pkg::INIT_RUN;
      end
      pmc_pkg::INIT_RUN: begin
        if (phyResetPulse) begin
          d.edpd      = pmc_pkg::EDPD_RST;
          d.rsvdRw    = pmc_pkg::RSVD_RW_RST;
          d.mode      = strapMode(q.straps);
          d.addr      = strapAddr(q.straps);
          d.modeApply = 1'b1;
        end else begin
          if (softResetPulse) begin
            d.edpd   = pmc_pkg::EDPD_RST;
            d.rsvdRw = pmc_pkg::RSVD_RW_RST;
          end else if (wrCtlStat) begin
            d.edpd   = regReq.wdata[pmc_pkg::EDPD_BIT];
            d.rsvdRw = regReq.wdata[pmc_pkg::RSVD_RW_BIT];
          end
          // The loader owns the bus during a reload, so its write wins.
          if (loaderWrEn) begin
            d.mode      = loaderWrData[pmc_pkg::MODE_MSB:pmc_pkg::MODE_LSB];
            d.addr      = loaderWrData[pmc_pkg::ADDR_MSB:pmc_pkg::ADDR_LSB];
            d.modeApply = 1'b1;
          end else if (wrModeAddr) begin
            d.mode      = regReq.wdata[pmc_pkg::MODE_MSB:pmc_pkg::MODE_LSB];
            d.addr      = regReq.wdata[pmc_pkg::ADDR_MSB:pmc_pkg::ADDR_LSB];
            d.modeApply = 1'b1;
          end
          if (reloadCmd) begin
            d.loaderReq = 1'b1;
          end
        end
      end
      default: begin
        d.init = pmc_pkg::INIT_SYNC0;
      end
    endcase
    if (regReq.rd) begin
      d.rdValid = 1'b1;
      d.rdData  = '0;
      if (regReq.idx == pmc_pkg::IDX_ENERGY_MODE_CTL_STAT) begin
        d.rdData[pmc_pkg::EDPD_BIT]    = q.edpd;
        d.rdData[pmc_pkg::ENERGY_BIT]  = line_energy_present;
        d.rdData[pmc_pkg::RSVD_RW_BIT] = q.rsvdRw;
      end else if (regReq.idx == pmc_pkg::IDX_OPERATING_MODE_ADDR) begin
        d.rdData[pmc_pkg::MODE_MSB:pmc_pkg::MODE_LSB] = q.mode;
        d.rdData[pmc_pkg::ADDR_MSB:pmc_pkg::ADDR_LSB] = q.addr;
      end
    end
    d.drive = pmc_pkg::pmcModeDecode(d.mode);
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      q        <= '0;
      q.init   <= pmc_pkg::INIT_SYNC0;
      q.edpd   <= pmc_pkg::EDPD_RST;
      q.rsvdRw <= pmc_pkg::RSVD_RW_RST;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Energy status
  // ----------------------------------------------------------------------
  pmc_energy_monitor #(
    .TIMEOUT_CYC (ENERGY_TIMEOUT_CYC)
  ) uEnergy (
    .clk_sys           (clk_sys),
    .rstSync_n         (rstSync_n),
    .clkEn             (clkEn),
    .forceOn           (phyResetPulse),
    .energySeen        (q.energySync2),
    .lineEnergyPresent (line_energy_present)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign regRdData               = q.rdData;
  assign regRdValid              = q.rdValid;
  assign loaderReq               = q.loaderReq;
  assign energyDetectPowerdownEn = q.edpd;
  assign lineEnergyPresent       = line_energy_present;
  assign phyMgmtAddress          = q.addr;
  assign scramblerSeed           = q.addr;
  assign phyMode                 = q.mode;
  assign modeDrive               = q.drive;
  assign modeApply               = q.modeApply;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence sLatchAuto;
    clkEn && q.init == pmc_pkg::INIT_LATCH && q.strapSync2.autoneg;
  endsequence

  sequence sLatchForced;
    clkEn && q.init == pmc_pkg::INIT_LATCH && !q.strapSync2.autoneg;
  endsequence

  sequence sQuietRun;
    clkEn && q.init == pmc_pkg::INIT_RUN && !phyResetPulse && !loaderWrEn && !wrModeAddr;
  endsequence

  a_edpd_write_takes: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    clkEn && q.init == pmc_pkg::INIT_RUN && wrCtlStat && !softResetPulse && !phyResetPulse
    |=> energyDetectPowerdownEn == $past(regReq.wdata[pmc_pkg::EDPD_BIT]))
    else $error("Power-down enable did not follow the write.");

  a_soft_keeps_energy: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    clkEn && softResetPulse && !phyResetPulse && !q.energySync2 && !line_energy_present |=> !lineEnergyPresent)
    else $error("Software reset changed the energy status.");

  a_phy_reset_energy: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    clkEn && phyResetPulse |=> lineEnergyPresent)
    else $error("Port reset did not force the energy status.");

  a_release_loader_req: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    sLatchAuto or sLatchForced |=> loaderReq && modeApply)
    else $error("No loader request after reset release.");

  a_reload_loader_req: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    clkEn && q.init == pmc_pkg::INIT_RUN && reloadCmd && !phyResetPulse |=> loaderReq)
    else $error("Reload command did not raise a loader request.");

  a_strap_mode_auto: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    sLatchAuto |=> phyMode == pmc_pkg::MODE_AUTONEG_RST)
    else $error("Autoneg strap did not give the all-ones mode.");

  a_strap_mode_forced: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    sLatchForced |=> phyMode == {1'b0, $past(q.strapSync2.speed), $past(q.strapSync2.duplex)})
    else $error("Forced mode default does not match the straps.");

  a_soft_keeps_mode: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    sQuietRun and softResetPulse |=> $stable(phyMode) && $stable(phyMgmtAddress) && !energyDetectPowerdownEn)
    else $error("Software reset disturbed the protected fields.");

  a_seed_follows_addr: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    scramblerSeed == phyMgmtAddress)
    else $error("Scrambler seed differs from the management address.");

  a_mode_100_drive: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    phyMode == 3'h4 |-> modeDrive.basicVal == 4'hc && modeDrive.advVal == 4'h4 && modeDrive.crsTxRx)
    else $error("Mode 100 drives the wrong bits.");

  a_mode_111_drive: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    phyMode == 3'h7 |-> modeDrive.basicMask == 4'h6 && modeDrive.basicVal == 4'h4 && modeDrive.advVal == 4'hf)
    else $error("Mode 111 drives the wrong bits.");

  a_mode_110_untouched: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    phyMode == 3'h6 |-> modeDrive.basicMask == 4'h0 && modeDrive.advMask == 4'h0 && modeDrive.powerDown)
    else $error("Power-down mode touched control bits.");

endmodule // pmc_phy_mode_regs

`default_nettype wire

// >>> testbench/pmc_phy_mode_regs_tb_top.sv
// Self-checking bench for the PHY energy/mode register and operating-mode/address register.
// Assumes pmc_pkg is compiled first; the energy timeout is shortened to 16 cycles.
`timescale 1ns/1ps
`default_nettype none

module pmc_phy_mode_regs_tb_top;
  typedef struct packed {
    logic [2:0]               mode;
    logic [4:0]               addr;
    pmc_pkg::pmc_mode_drive_t drv;
  } pmc_tb_row_t;

  // ----------------------------------------------------------------------
  // Mode table: written mode and address, expected decode
  // ----------------------------------------------------------------------
  localparam logic [4:0]  IDX_A  = pmc_pkg::IDX_ENERGY_MODE_CTL_STAT;
  localparam logic [4:0]  IDX_B  = pmc_pkg::IDX_OPERATING_MODE_ADDR;
  localparam pmc_tb_row_t ROWS [8] = '{
    {3'h0, 5'h00, 4'hf, 4'h0, 4'h0, 4'h0, 3'h4},
    {3'h1, 5'h05, 4'hf, 4'h1, 4'h0, 4'h0, 3'h0},
    {3'h2, 5'h0a, 4'hf, 4'h8, 4'h0, 4'h0, 3'h4},
    {3'h3, 5'h10, 4'hf, 4'h9, 4'h0, 4'h0, 3'h0},
    {3'h4, 5'h15, 4'hf, 4'hc, 4'hf, 4'h4, 3'h4},
    {3'h5, 5'h1a, 4'hf, 4'hc, 4'hf, 4'h4, 3'h2},
    {3'h6, 5'h1e, 4'h0, 4'h0, 4'h0, 4'h0, 3'h1},
    {3'h7, 5'h1f, 4'h6, 4'h4, 4'hf, 4'hf, 3'h4}
  };

  logic                     clk_sys;
  logic                     rst_n;
  logic                     clkEn;
  pmc_pkg::pmc_reg_req_t    regReq;
  logic [15:0]              regRdData;
  logic                     regRdValid;
  logic                     softResetPulse;
  logic                     phyResetPulse;
  logic                     reloadCmd;
  logic                     loaderWrEn;
  logic [15:0]              loaderWrData;
  logic                     loaderReq;
  pmc_pkg::pmc_straps_t     strapPins;
  logic                     lineEnergyPin;
  logic                     energyDetectPowerdownEn;
  logic                     lineEnergyPresent;
  logic [4:0]               phyMgmtAddress;
  logic [4:0]               scramblerSeed;
  logic [2:0]               phyMode;
  pmc_pkg::pmc_mode_drive_t modeDrive;
  logic                     modeApply;
  int                       errors;
  int                       cmp_count;
  int                       cycles;

  pmc_phy_mode_regs #(
    .ENERGY_TIMEOUT_CYC (16)
  ) pmc_phy_mode_regs_inst (
    .clk_sys                 (clk_sys),
    .rst_n                   (rst_n),
    .clkEn                   (clkEn),
    .regReq                  (regReq),
    .regRdData               (regRdData),
    .regRdValid              (regRdValid),
    .softResetPulse          (softResetPulse),
    .phyResetPulse           (phyResetPulse),
    .reloadCmd               (reloadCmd),
    .loaderWrEn              (loaderWrEn),
    .loaderWrData            (loaderWrData),
    .loaderReq               (loaderReq),
    .strapPins               (strapPins),
    .lineEnergyPin           (lineEnergyPin),
    .energyDetectPowerdownEn (energyDetectPowerdownEn),
    .lineEnergyPresent       (lineEnergyPresent),
    .phyMgmtAddress          (phyMgmtAddress),
    .scramblerSeed           (scramblerSeed),
    .phyMode                 (phyMode),
    .modeDrive               (modeDrive),
    .modeApply               (modeApply)
  );

  // ----------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // The whole run needs well under 1000 cycles; the ceiling leaves ample margin.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic regWrite(input logic [4:0] idx, input logic [15:0] data);
    @(negedge clk_sys);
    regReq = {1'b0, 1'b1, idx, data};
    @(negedge clk_sys);
    regReq = '0;
  endtask

  task automatic regCheck(input logic [4:0] idx, input logic [15:0] exp);
    @(negedge clk_sys);
    regReq = {1'b1, 1'b0, idx, 16'h0000};
    @(negedge clk_sys);
    regReq = '0;
    check("regRdValid", regRdValid, 1'b1);
    check("regRdData", regRdData, exp);
  endtask

  task automatic hwReset;
    rst_n = 1'b0;
    waitCyc(16);
    rst_n = 1'b1;
    waitCyc(10);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    regReq = '0;
    softResetPulse = 1'b0;
    phyResetPulse = 1'b0;
    reloadCmd = 1'b0;
    loaderWrEn = 1'b0;
    loaderWrData = 16'h0000;
    clkEn = 1'b1;
    strapPins = {1'b0, 1'b1, 1'b0, 1'b1};
    lineEnergyPin = 1'b1;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    hwReset();
    regCheck(IDX_B, {8'h00, 3'h2, pmc_pkg::ADDR_SEL1_DEF});
    regCheck(IDX_A, 16'h0002);
    // Straps moved after capture must not matter later.
    strapPins = {1'b1, 1'b1, 1'b1, 1'b0};
    foreach (ROWS[i]) begin
      regWrite(IDX_B, {8'hff, ROWS[i].mode, ROWS[i].addr});
      check("modeApply", modeApply, 1'b1);
      check("phyMode", phyMode, ROWS[i].mode);
      check("phyMgmtAddress", phyMgmtAddress, ROWS[i].addr);
      check("scramblerSeed", scramblerSeed, ROWS[i].addr);
      check("modeDrive", modeDrive, ROWS[i].drv);
      regCheck(IDX_B, {8'h00, ROWS[i].mode, ROWS[i].addr});
    end
    regCheck(5'h00, 16'h0000);
    regWrite(5'h13, 16'h0000);
    regCheck(IDX_B, {8'h00, 3'h7, 5'h1f});
    regWrite(IDX_A, 16'hffff);
    check("edpd", energyDetectPowerdownEn, 1'b1);
    regCheck(IDX_A, 16'h2003);
    @(negedge clk_sys);
    regReq = {1'b0, 1'b1, IDX_B, 16'h0011};
    loaderWrEn = 1'b1;
    loaderWrData = 16'h00aa;
    @(negedge clk_sys);
    regReq = '0;
    loaderWrEn = 1'b0;
    check("phyMode", phyMode, 3'h5);
    check("phyMgmtAddress", phyMgmtAddress, 5'h0a);
    // A low clock enable must drop the write and freeze the fields.
    clkEn = 1'b0;
    regWrite(IDX_B, 16'h0033);
    check("phyMode", phyMode, 3'h5);
    check("phyMgmtAddress", phyMgmtAddress, 5'h0a);
    clkEn = 1'b1;
    @(negedge clk_sys);
    reloadCmd = 1'b1;
    @(negedge clk_sys);
    reloadCmd = 1'b0;
    check("loaderReq", loaderReq, 1'b1);
    // energy drops after the quiet timeout
    lineEnergyPin = 1'b0;
    waitCyc(30);
    check("energy", lineEnergyPresent, 1'b0);
    regCheck(IDX_A, 16'h2001);
    // software reset keeps energy and protected fields
    @(negedge clk_sys);
    softResetPulse = 1'b1;
    @(negedge clk_sys);
    softResetPulse = 1'b0;
    waitCyc(1);
    check("energy", lineEnergyPresent, 1'b0);
    check("edpd", energyDetectPowerdownEn, 1'b0);
    check("phyMode", phyMode, 3'h5);
    // port reset restores the latched strap defaults
    @(negedge clk_sys);
    phyResetPulse = 1'b1;
    @(negedge clk_sys);
    phyResetPulse = 1'b0;
    waitCyc(1);
    check("energy", lineEnergyPresent, 1'b1);
    check("phyMode", phyMode, 3'h2);
    check("phyMgmtAddress", phyMgmtAddress, pmc_pkg::ADDR_SEL1_DEF);
    waitCyc(30);
    check("energy", lineEnergyPresent, 1'b0);
    lineEnergyPin = 1'b1;
    waitCyc(5);
    check("energy", lineEnergyPresent, 1'b1);
    // autonegotiation strap on a second chip reset
    hwReset();
    check("phyMode", phyMode, 3'h7);
    check("phyMgmtAddress", phyMgmtAddress, pmc_pkg::ADDR_SEL0_DEF);
    regCheck(IDX_A, 16'h0002);
    end_sim();
  end
endmodule // pmc_phy_mode_regs_tb_top

`default_nettype wire
